// *** hw/lcx_core.sv ***
// Decode and execute slice: logic ops, control read, return, byte store, system call
`timescale 1ns/1ps

//Function
// RQ1: Complement writes the bitwise inverse of src_reg_a via XNOR with zero_reg in one cycle.
// RQ2: Register OR writes src_reg_a OR src_reg_b to the destination in one cycle.
// RQ3: Immediate OR zero-extends immediate_16 and ORs it with src_reg_a in one cycle.
// RQ4: Upper OR shifts immediate_16 left by 16 and ORs it with src_reg_a.
// RQ5: Control read copies the selected control register into the destination in one cycle; the code writes it back in the cycle after issue.
// RQ6: Return loads the program counter from return_address_reg, occupying four issue cycles.
// RQ7: Byte store writes only the low byte of src_reg_b at base plus sign-extended immediate.
// RQ8: System call saves the program counter into exception_return_reg over four issue cycles.
// RQ9: System call copies global_irq_enable into saved_irq_enable, then clears global.
// RQ10: System call jumps to identifier times 32 past the debug or normal exception base.
// RQ11: The zero register always reads as zero.
module lcx_core (
    input  wire logic                 clk_sys,
    input  wire logic                 arst_n,
    input  wire logic                 ce,
    input  wire logic                 instr_valid,
    input  wire logic [31:0]          instr,
    input  wire logic [31:0]          exception_base,
    input  wire logic [31:0]          debug_exception_base,
    input  wire logic                 remap_all_exceptions,
    input  wire logic [31:0]          pc_reset_value,
    output logic                      instr_ready,
    output logic                      csr_rd_en,
    output logic [4:0]                csr_sel,
    input  wire logic [31:0]          csr_rd_data,
    output lcx_pkg::lcx_store_s       store_req,
    output lcx_pkg::lcx_wb_s          wb_out,
    output logic [31:0]               pc,
    output logic                      global_irq_enable,
    output logic                      saved_irq_enable,
    output logic                      exc_taken
);
    lcx_pkg::lcx_state_e state_reg;
    logic [1:0]   busy_cnt_reg;
    logic [5:0]   opc;
    logic [4:0]   f1;
    logic [4:0]   f2;
    logic [4:0]   f3;
    logic [15:0]  imm;
    logic [31:0]  rd_a;
    logic [31:0]  rd_b;
    logic [31:0]  alu_res;
    logic [4:0]   rd_a_idx;
    logic [4:0]   rd_b_idx;
    logic         issue;
    logic         is_logic;
    logic         is_rdctl;
    logic         is_ret;
    logic         is_stb;
    logic         is_sysc;
    logic         wb_en;
    logic [4:0]   wb_idx;
    logic [31:0]  wb_data;
    logic         rdctl_pend_reg;
    logic [4:0]   rdctl_dst_reg;
    logic [31:0]  pc_next;
    logic [31:0]  exc_target;

    // Field extraction
    assign opc = instr[lcx_pkg::OPC_HI:lcx_pkg::OPC_LO];
    assign f1  = instr[lcx_pkg::F1_HI:lcx_pkg::F1_LO];
    assign f2  = instr[lcx_pkg::F2_HI:lcx_pkg::F2_LO];
    assign f3  = instr[lcx_pkg::F3_HI:lcx_pkg::F3_LO];
    assign imm = instr[lcx_pkg::IMM_W-1:0];

    // Decode, taken only while idle and no control read holds the write port
    assign issue    = ce && instr_valid && state_reg == lcx_pkg::LCX_IDLE
                   && !rdctl_pend_reg;                   // see RQ5
    assign is_logic = opc == lcx_pkg::OPC_XNOR || opc == lcx_pkg::OPC_OR
                   || opc == lcx_pkg::OPC_ORI  || opc == lcx_pkg::OPC_ORHI;
    assign is_rdctl = opc == lcx_pkg::OPC_RDCTL;
    assign is_ret   = opc == lcx_pkg::OPC_BRREG;
    assign is_stb   = opc == lcx_pkg::OPC_STB;
    assign is_sysc  = instr == lcx_pkg::SYSC_WORD;

    // Register read ports; register-form ops use f2 as second source
    assign rd_a_idx = f1;
    assign rd_b_idx = f2;

    // Writeback source: logic result or system call pc now, control read the cycle after
    always_comb begin
        wb_en   = 1'b0;
        wb_idx  = lcx_pkg::ZERO_IDX;
        wb_data = '0;
        if (rdctl_pend_reg) begin
            wb_en   = 1'b1;
            wb_idx  = rdctl_dst_reg;
            wb_data = csr_rd_data;                       // see RQ5
        end else if (issue && is_logic) begin
            wb_en   = 1'b1;
            wb_idx  = (opc == lcx_pkg::OPC_ORI || opc == lcx_pkg::OPC_ORHI) ? f2 : f3;
            wb_data = alu_res;                           // see RQ1
        end else if (issue && is_sysc) begin
            wb_en   = 1'b1;
            wb_idx  = lcx_pkg::EXC_RET_IDX;
            wb_data = pc;                                // see RQ8
        end
    end

    lcx_regfile #(
        .DW (lcx_pkg::DATA_W),
        .AW (lcx_pkg::REG_AW)
    ) u_rf (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .ce        (ce),
        .rd_a_idx  (rd_a_idx),
        .rd_b_idx  (rd_b_idx),
        .rd_a_data (rd_a),
        .rd_b_data (rd_b),
        .wr_en     (wb_en),
        .wr_idx    (wb_idx),
        .wr_data   (wb_data)
    );

    lcx_alu u_alu (
        .opc    (opc),
        .op_a   (rd_a),
        .op_b   (rd_b),
        .imm    (imm),
        .result (alu_res)
    );

    // Exception vector select
    assign exc_target = (remap_all_exceptions ? debug_exception_base : exception_base)
                      + {24'h000000, lcx_pkg::EID_SYSCALL, 5'h00};    // see RQ10

    // Next program counter
    always_comb begin
        pc_next = pc;
        if (issue) begin
            if (is_sysc) begin
                pc_next = exc_target;                    // see RQ10
            end else if (is_ret) begin
                pc_next = rd_a;                          // see RQ6
            end else begin
                pc_next = pc + 32'h00000004;
            end
        end
    end

    // Program counter register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pc <= '0;
        end else if (ce) begin
            pc <= pc_next;
        end
    end

    // Multi-cycle occupancy for branch and system call
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg    <= lcx_pkg::LCX_IDLE;
            busy_cnt_reg <= '0;
        end else if (ce) begin
            case (state_reg)
                lcx_pkg::LCX_IDLE: begin
                    if (issue && (is_ret || is_sysc)) begin
                        state_reg    <= lcx_pkg::LCX_STALL;  // see RQ6
                        busy_cnt_reg <= lcx_pkg::BR_ISSUE_CYC - 2'h1;
                    end
                end
                lcx_pkg::LCX_STALL: begin
                    if (busy_cnt_reg == '0) begin
                        state_reg <= lcx_pkg::LCX_IDLE;
                    end else begin
                        busy_cnt_reg <= busy_cnt_reg - 2'h1;
                    end
                end
                default: state_reg <= lcx_pkg::LCX_IDLE;
            endcase
        end
    end

    // Ready: idle and not about to stall
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            instr_ready <= 1'b0;
        end else if (ce) begin
            instr_ready <= (state_reg == lcx_pkg::LCX_IDLE
                            && !(issue && (is_ret || is_sysc || is_rdctl)))
                        || (state_reg == lcx_pkg::LCX_STALL && busy_cnt_reg == '0);
        end
    end

    // Control register read request
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            csr_rd_en      <= 1'b0;
            csr_sel        <= '0;
            rdctl_pend_reg <= 1'b0;
            rdctl_dst_reg  <= '0;
        end else if (ce) begin
            csr_rd_en      <= issue && is_rdctl;         // see RQ5
            csr_sel        <= f1;
            rdctl_pend_reg <= issue && is_rdctl;
            rdctl_dst_reg  <= f3;
        end
    end

    // Byte store toward data memory
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            store_req <= '0;
        end else if (ce) begin
            store_req.valid <= issue && is_stb;
            store_req.addr  <= rd_a + {{16{imm[15]}}, imm};             // see RQ7
            store_req.data  <= rd_b[7:0] & lcx_pkg::BYTE_MASK;          // see RQ7
            store_req.lanes <= (issue && is_stb) ? lcx_pkg::LANE_ONE : lcx_pkg::LANE_NONE;
        end
    end

    // Interrupt enable save and clear on system call
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            global_irq_enable <= lcx_pkg::IE_RESET;
            saved_irq_enable  <= 1'b0;
            exc_taken         <= 1'b0;
        end else if (ce) begin
            exc_taken <= issue && is_sysc;
            if (issue && is_sysc) begin
                saved_irq_enable  <= global_irq_enable;  // see RQ9
                global_irq_enable <= 1'b0;               // see RQ9
            end
        end
    end

    // Registered writeback view
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wb_out <= '0;
        end else if (ce) begin
            wb_out.valid <= wb_en;
            wb_out.idx   <= wb_idx;
            wb_out.data  <= wb_data;
        end
    end

    // Properties on results, vectors and occupancy
    a_sysc_save_ie: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && issue && is_sysc |=> saved_irq_enable == $past(global_irq_enable)
        && !global_irq_enable) else $error("irq enable not saved"); // see RQ9
    a_sysc_vector: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && issue && is_sysc |=> pc == $past(exc_target)
        && exc_taken) else $error("bad exception vector"); // see RQ10
    a_sysc_ea: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && issue && is_sysc |=> wb_out.valid && wb_out.idx == lcx_pkg::EXC_RET_IDX
        && wb_out.data == $past(pc)) else $error("return pc not saved"); // see RQ8
    a_ret_target: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && issue && is_ret |=> pc == $past(rd_a)) else $error("return target wrong"); // see RQ6
    a_ret_four: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && issue && (is_ret || is_sysc) |=> (state_reg == lcx_pkg::LCX_STALL) [*3]
        ##1 state_reg == lcx_pkg::LCX_IDLE) else $error("occupancy not four"); // see RQ6
    a_or_result: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && issue && opc == lcx_pkg::OPC_OR |=> wb_out.valid
        && wb_out.data == ($past(rd_a) | $past(rd_b))) else $error("or result wrong"); // see RQ2
    a_not_result: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && issue && opc == lcx_pkg::OPC_XNOR && f2 == '0 |=> wb_out.valid
        && wb_out.data == ~$past(rd_a)) else $error("complement wrong"); // see RQ1
    a_ori_result: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && issue && opc == lcx_pkg::OPC_ORI |=> wb_out.data[31:16] == $past(rd_a[31:16]))
        else $error("ori high half wrong"); // see RQ3
    a_orhi_result: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && issue && opc == lcx_pkg::OPC_ORHI |=> wb_out.data[15:0] == $past(rd_a[15:0]))
        else $error("orhi low half wrong"); // see RQ4
    a_rdctl_wb: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && issue && is_rdctl ##1 ce |=> wb_out.valid && wb_out.data == $past(csr_rd_data))
        else $error("control read lost"); // see RQ5
    a_stb_byte: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ce && issue && is_stb |=> store_req.valid && store_req.lanes == lcx_pkg::LANE_ONE
        && store_req.data == $past(rd_b[7:0])) else $error("byte store wrong"); // see RQ7

    // Request, ready, freeze, address, pc step and trap pulse checks
    a_rdctl_sel: assert property (@(posedge clk_sys) disable iff (!arst_n) // see RQ5
        ce && issue && is_rdctl |=> csr_rd_en && csr_sel == $past(f1))
        else $error("control select wrong");
    a_ready_stall: assert property (@(posedge clk_sys) disable iff (!arst_n) // see RQ6
        ce && issue && (is_ret || is_sysc) |=> !instr_ready)
        else $error("ready during stall");
    a_ce_freeze: assert property (@(posedge clk_sys) disable iff (!arst_n) // Clock enable
        !ce |=> $stable(pc) && $stable(wb_out) && $stable(state_reg))
        else $error("state moved while frozen");
    a_stb_addr: assert property (@(posedge clk_sys) disable iff (!arst_n) // see RQ7
        ce && issue && is_stb |=> store_req.addr == $past(rd_a) + 32'(signed'($past(imm))))
        else $error("store address wrong");
    a_pc_step: assert property (@(posedge clk_sys) disable iff (!arst_n) // Sequential advance
        ce && issue && !is_ret && !is_sysc |=> pc == $past(pc) + 32'h00000004)
        else $error("pc did not advance");
    a_exc_pulse: assert property (@(posedge clk_sys) disable iff (!arst_n) // see RQ8
        exc_taken && ce |=> !exc_taken) else $error("trap flag stuck");

    // Scenario covers
    c_sysc: cover property (@(posedge clk_sys) issue && is_sysc);
    c_ret: cover property (@(posedge clk_sys) issue && is_ret);
    c_stb: cover property (@(posedge clk_sys) issue && is_stb);
    c_rdctl: cover property (@(posedge clk_sys) issue && is_rdctl);
    c_sysc_remap: cover property (@(posedge clk_sys) issue && is_sysc && remap_all_exceptions);
endmodule : lcx_core

// *** hw/lcx_pkg.sv ***
// Package: opcodes, field layouts, constants and carriers for the decoder slice
package lcx_pkg;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned REG_AW     = 5;
    localparam int unsigned IMM_W      = 16;
    // Field positions in the instruction word
    localparam int unsigned OPC_HI     = 31;
    localparam int unsigned OPC_LO     = 26;
    localparam int unsigned F1_HI      = 25;
    localparam int unsigned F1_LO      = 21;
    localparam int unsigned F2_HI      = 20;
    localparam int unsigned F2_LO      = 16;
    localparam int unsigned F3_HI      = 15;
    localparam int unsigned F3_LO      = 11;
    localparam int unsigned UPPER_SH   = 16;
    localparam int unsigned EID_SH     = 5;   // Identifier times 32
    localparam int unsigned EID_W      = 3;
    // Primary opcodes
    localparam logic [5:0] OPC_XNOR    = 6'h29;
    localparam logic [5:0] OPC_OR      = 6'h2e;
    localparam logic [5:0] OPC_ORI     = 6'h0e;
    localparam logic [5:0] OPC_ORHI    = 6'h1e;
    localparam logic [5:0] OPC_RDCTL   = 6'h24;
    localparam logic [5:0] OPC_BRREG   = 6'h30;
    localparam logic [5:0] OPC_STB     = 6'h0c;
    localparam logic [5:0] OPC_SYSC    = 6'h2b;
    localparam logic [31:0] SYSC_WORD  = 32'hac000007;
    // Special register indices
    localparam logic [4:0] ZERO_IDX    = 5'h00;
    localparam logic [4:0] EXC_RET_IDX = 5'h1e;
    localparam logic [4:0] RET_ADR_IDX = 5'h1d;
    localparam logic [2:0] EID_SYSCALL = 3'h7;
    // Issue occupancy
    localparam logic [1:0] BR_ISSUE_CYC = 2'h3;  // Extra cycles, four total
    localparam logic [7:0] BYTE_MASK   = 8'hff;
    localparam logic [3:0] LANE_NONE   = 4'h0;
    localparam logic [3:0] LANE_ONE    = 4'h1;
    localparam logic       IE_RESET    = 1'b1;   // Interrupts enabled out of reset

    typedef enum logic [1:0] {
        LCX_IDLE  = 2'b00,
        LCX_STALL = 2'b01
    } lcx_state_e;

    // Byte store request toward data memory
    typedef struct packed {
        logic              valid;
        logic [31:0]       addr;
        logic [7:0]        data;
        logic [3:0]        lanes;
    } lcx_store_s;

    // Register writeback
    typedef struct packed {
        logic              valid;
        logic [4:0]        idx;
        logic [31:0]       data;
    } lcx_wb_s;
endpackage : lcx_pkg

// *** hw/lcx_regfile.sv ***
// General register file with zero register hardwired
`timescale 1ns/1ps
module lcx_regfile #(
    parameter int unsigned DW = 32,
    parameter int unsigned AW = 5
) (
    input  wire logic          clk_sys,
    input  wire logic          arst_n,
    input  wire logic          ce,
    input  wire logic [AW-1:0] rd_a_idx,
    input  wire logic [AW-1:0] rd_b_idx,
    output logic      [DW-1:0] rd_a_data,
    output logic      [DW-1:0] rd_b_data,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_idx,
    input  wire logic [DW-1:0] wr_data
);
    logic [DW-1:0] mem_reg [2**AW];

    // Entry zero never written
    genvar g;
    generate
        for (g = 0; g < 2**AW; g++) begin : g_ent
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    mem_reg[g] <= '0;
                end else if (ce && wr_en && wr_idx == AW'(g) && g != 0) begin
                    mem_reg[g] <= wr_data;
                end
            end
        end
    endgenerate

    // Zero register reads as zero
    assign rd_a_data = (rd_a_idx == '0) ? '0 : mem_reg[rd_a_idx]; // see RQ11
    assign rd_b_data = (rd_b_idx == '0) ? '0 : mem_reg[rd_b_idx]; // see RQ11

    a_zero_reads: assert property (@(posedge clk_sys) disable iff (!arst_n)
        rd_a_idx == '0 |-> rd_a_data == '0) else $error("zero register nonzero"); // see RQ11
endmodule : lcx_regfile

// *** hw/lcx_alu.sv ***
// Logic unit for complement, OR and upper OR
`timescale 1ns/1ps
module lcx_alu (
    input  wire logic [5:0]  opc,
    input  wire logic [31:0] op_a,
    input  wire logic [31:0] op_b,
    input  wire logic [15:0] imm,
    output logic      [31:0] result
);
    // Operation select
    always_comb begin
        case (opc)
            lcx_pkg::OPC_XNOR: result = ~(op_a ^ op_b);                 // see RQ1
            lcx_pkg::OPC_OR:   result = op_a | op_b;                     // see RQ2
            lcx_pkg::OPC_ORI:  result = op_a | {16'h0000, imm};          // see RQ3
            lcx_pkg::OPC_ORHI: result = op_a | {imm, 16'h0000};          // see RQ4
            default:           result = '0;
        endcase
    end
endmodule : lcx_alu

// *** sim/lcx_mem_model.sv ***
// Data memory model on the far side of the byte store path
`timescale 1ns/1ps
module lcx_mem_model (
    input wire logic                clk_sys,
    input wire logic                arst_n,
    input lcx_pkg::lcx_store_s      store_req
);
    logic [7:0]           mem [logic [31:0]];
    lcx_pkg::lcx_store_s  seen_q[$];

    // Writes one byte per accepted store, keeps every request for the bench
    always @(posedge clk_sys) begin
        if (arst_n === 1'b1 && store_req.valid === 1'b1) begin
            mem[store_req.addr] = store_req.data;
            seen_q.push_back(store_req);
        end
    end
endmodule : lcx_mem_model

// *** sim/testbench.sv ***
// Testbench for the decoder slice: logic ops, control read, return, byte store, system call
`timescale 1ns/1ps
module testbench;
    localparam logic [31:0] R1_V = 32'h1234_8765;
    localparam logic [31:0] R2_V = 32'h0f0f_00f0;
    logic                 clk_sys;
    logic                 arst_n;
    logic                 ce;
    logic                 instr_ready;
    logic                 instr_valid;
    logic [31:0]          instr;
    logic [31:0]          exception_base;
    logic [31:0]          debug_exception_base;
    logic                 remap_all_exceptions;
    logic                 csr_rd_en;
    logic [4:0]           csr_sel;
    logic [31:0]          csr_rd_data;
    lcx_pkg::lcx_store_s  store_req;
    lcx_pkg::lcx_wb_s     wb_out;
    logic [31:0]          pc;
    logic                 global_irq_enable;
    logic                 saved_irq_enable;
    logic                 exc_taken;
    lcx_pkg::lcx_wb_s     wb_q[$];
    logic [4:0]           sel_tab [3] = '{5'h00, 5'h0a, 5'h1f};
    logic [31:0]          exp_pc;
    logic [31:0]          old_pc;
    int                   fails = 0;
    int                   num_checks = 0;
    int                   exc_cnt = 0;

    lcx_core u_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .instr_valid(instr_valid),
        .instr(instr), .exception_base(exception_base),
        .debug_exception_base(debug_exception_base),
        .remap_all_exceptions(remap_all_exceptions), .pc_reset_value(32'h0000_0000),
        .instr_ready(instr_ready), .csr_rd_en(csr_rd_en), .csr_sel(csr_sel),
        .csr_rd_data(csr_rd_data), .store_req(store_req), .wb_out(wb_out), .pc(pc),
        .global_irq_enable(global_irq_enable), .saved_irq_enable(saved_irq_enable),
        .exc_taken(exc_taken)
    );

    lcx_mem_model u_mem (.clk_sys(clk_sys), .arst_n(arst_n), .store_req(store_req));

    // Control register contents; inverted when not read so stale use shows
    function automatic logic [31:0] csr_val(input logic [4:0] s);
        return {16'hc5e0, 11'h000, s};
    endfunction : csr_val
    assign csr_rd_data = csr_rd_en ? csr_val(csr_sel) : ~csr_val(csr_sel);

    function automatic logic [31:0] rtype(input logic [5:0] o, input logic [4:0] a,
                                          input logic [4:0] b, input logic [4:0] d);
        return {o, a, b, d, 11'h000};
    endfunction : rtype
    function automatic logic [31:0] itype(input logic [5:0] o, input logic [4:0] a,
                                          input logic [4:0] b, input logic [15:0] k);
        return {o, a, b, k};
    endfunction : itype

    // Clock and result monitors
    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (wb_out.valid === 1'b1) wb_q.push_back(wb_out);
        if (exc_taken === 1'b1) exc_cnt++;
    end

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // Presents a word for one edge and leaves the request up
    task automatic drive(input logic [31:0] w);
        instr = w;
        instr_valid = 1'b1;
        @(posedge clk_sys);
        #1;
    endtask : drive
    task automatic idle(input int n);
        instr_valid = 1'b0;
        repeat (n) begin
            @(posedge clk_sys);
            #1;
        end
    endtask : idle
    task automatic issue(input logic [31:0] w);
        drive(w);
        exp_pc = exp_pc + 32'h4;
        idle(1);
    endtask : issue

    task automatic expect_wb(input logic [4:0] idx, input logic [31:0] d);
        lcx_pkg::lcx_wb_s w;
        for (int i = 0; i < 6 && wb_q.size() == 0; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (wb_q.size() == 0) begin
            chk("writeback present", 32'h1, 32'h0);
        end else begin
            w = wb_q.pop_front();
            chk("writeback index", 32'(idx), 32'(w.idx));
            chk("writeback data", d, w.data);
        end
    endtask : expect_wb

    task automatic set_reg(input logic [4:0] x, input logic [31:0] v);
        issue(itype(lcx_pkg::OPC_ORI, lcx_pkg::ZERO_IDX, x, v[15:0]));
        expect_wb(x, {16'h0000, v[15:0]});
        issue(itype(lcx_pkg::OPC_ORHI, x, x, v[31:16]));
        expect_wb(x, v);
    endtask : set_reg

    task automatic chk_store(input logic [31:0] a, input logic [7:0] d);
        lcx_pkg::lcx_store_s s;
        if (u_mem.seen_q.size() == 0) begin
            chk("store present", 32'h1, 32'h0);
        end else begin
            s = u_mem.seen_q.pop_front();
            chk("store address", a, s.addr);
            chk("store byte", {24'h0, d}, {24'h0, s.data});
            chk("store lanes", {28'h0, lcx_pkg::LANE_ONE}, {28'h0, s.lanes});
            chk("neighbour byte untouched", 32'h0, 32'(u_mem.mem.exists(a + 32'h1)));
        end
    endtask : chk_store

    // Branch or trap, then a probe held for four edges: only the last is taken
    task automatic occupy(input logic [31:0] w, input logic [4:0] x, input logic [15:0] k);
        drive(w);
        chk("ready in stall", 32'h0, 32'(instr_ready));
        repeat (4) drive(itype(lcx_pkg::OPC_ORI, lcx_pkg::ZERO_IDX, x, k));
        idle(3);
        chk("ready after stall", 32'h1, 32'(instr_ready));
    endtask : occupy

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    initial begin
        #20us;
        fails++;
        $display("watchdog expired before the tests ended");
        wrap_up;
    end

    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        instr_valid = 1'b0;
        instr = 32'h0000_0000;
        exception_base = 32'h0000_2000;
        debug_exception_base = 32'h0001_0000;
        remap_all_exceptions = 1'b0;
        exp_pc = 32'h0000_0000;
        repeat (10) @(posedge clk_sys);
        #1;
        arst_n = 1'b1;
        set_reg(5'h01, R1_V);
        set_reg(5'h02, R2_V);
        $display("test immediates done");
        drive(rtype(lcx_pkg::OPC_OR, 5'h01, 5'h02, 5'h03));
        drive(rtype(lcx_pkg::OPC_XNOR, 5'h01, lcx_pkg::ZERO_IDX, 5'h04));
        idle(1);
        exp_pc = exp_pc + 32'h8;
        expect_wb(5'h03, R1_V | R2_V);
        expect_wb(5'h04, ~R1_V);
        issue(itype(lcx_pkg::OPC_ORI, lcx_pkg::ZERO_IDX, lcx_pkg::ZERO_IDX, 16'hffff));
        idle(4);
        wb_q.delete();
        issue(rtype(lcx_pkg::OPC_XNOR, 5'h02, lcx_pkg::ZERO_IDX, 5'h05));
        expect_wb(5'h05, ~R2_V);
        issue(rtype(lcx_pkg::OPC_OR, lcx_pkg::ZERO_IDX, lcx_pkg::ZERO_IDX, 5'h06));
        expect_wb(5'h06, 32'h0000_0000);
        $display("test register ops done");
        for (int s = 0; s < 3; s++) begin
            issue(rtype(lcx_pkg::OPC_RDCTL, sel_tab[s], 5'h00, 5'h07));
            expect_wb(5'h07, csr_val(sel_tab[s]));
        end
        $display("test control read done");
        ce = 1'b0;
        old_pc = pc;
        repeat (2) drive(rtype(lcx_pkg::OPC_OR, 5'h01, 5'h02, 5'h0a));
        chk("pc frozen", old_pc, pc);
        chk("writes frozen", 32'h0, 32'(wb_q.size()));
        ce = 1'b1;
        issue(rtype(lcx_pkg::OPC_OR, 5'h01, 5'h02, 5'h0a));
        expect_wb(5'h0a, R1_V | R2_V);
        $display("test clock enable done");
        drive(itype(lcx_pkg::OPC_STB, 5'h01, 5'h02, 16'hfff8));
        drive(itype(lcx_pkg::OPC_STB, 5'h02, 5'h01, 16'h0010));
        idle(3);
        exp_pc = exp_pc + 32'h8;
        chk_store(R1_V - 32'h8, R2_V[7:0]);
        chk_store(R2_V + 32'h10, R1_V[7:0]);
        chk("store writeback", 32'h0, 32'(wb_q.size()));
        $display("test byte store done");
        set_reg(lcx_pkg::RET_ADR_IDX, 32'h0000_0400);
        occupy(rtype(lcx_pkg::OPC_BRREG, lcx_pkg::RET_ADR_IDX, 5'h00, 5'h00), 5'h08, 16'h1111);
        chk("writebacks after return", 32'h1, 32'(wb_q.size()));
        expect_wb(5'h08, 32'h0000_1111);
        exp_pc = 32'h0000_0404;
        chk("pc after return", exp_pc, pc);
        $display("test return done");
        for (int m = 0; m < 2; m++) begin
            remap_all_exceptions = m[0];
            old_pc = exp_pc;
            occupy(lcx_pkg::SYSC_WORD, 5'h09, 16'h2222);
            chk("writebacks after trap", 32'h2, 32'(wb_q.size()));
            expect_wb(lcx_pkg::EXC_RET_IDX, old_pc);
            expect_wb(5'h09, 32'h0000_2222);
            exp_pc = (m[0] ? debug_exception_base : exception_base)
                     + 32'(lcx_pkg::EID_SYSCALL) * 32'd32 + 32'h4;
            chk("pc past vector", exp_pc, pc);
            chk("global enable", 32'h0, 32'(global_irq_enable));
            chk("saved enable", 32'(m == 0), 32'(saved_irq_enable));
        end
        chk("traps taken", 32'h2, 32'(exc_cnt));
        $display("test system call done");
        wrap_up;
    end
endmodule : testbench
